// file: core/boc_regs.vh
`ifndef BOC_REGS_VH
`define BOC_REGS_VH
`define BOC_CLK_HZ         25000000
`define BOC_TICK_MS        20
`define BOC_TICK_CYC       ((`BOC_CLK_HZ / 1000) * `BOC_TICK_MS)
`define BOC_TRAVERSE_DEF   16'd10
`define BOC_CLOSE_PULSE_DEF 16'd10
`define BOC_OPEN_PULSE_DEF 16'd10
`define BOC_TERM_DEF       16'd500
`define BOC_FTRIP_DEF      16'd10
`define BOC_POS_INTER      2'h0
`define BOC_POS_OPEN       2'h1
`define BOC_POS_CLOSED     2'h2
`define BOC_POS_BAD        2'h3
`define BOC_TYPE_WD        2'h0
`define BOC_TYPE_CB        2'h1
`define BOC_TYPE_MCD       2'h2
`define BOC_TYPE_GND       2'h3
`define BOC_RDY_OFF        2'h0
`define BOC_RDY_HIGH       2'h1
`define BOC_RDY_LOW        2'h2
`define BOC_LVL_USER       2'h0
`define BOC_LVL_OPER       2'h1
`define BOC_LVL_CONF       2'h2
`define BOC_LVL_SUPER      2'h3
`endif

// file: core/boc_pos_decode.v
`timescale 1ns/1ns
`default_nettype none
`include "boc_regs.vh"
// Two-input position decoder with traverse timing
module boc_pos_decode #(
	parameter TW = 16
) (
	input  wire          mclk,       // System clock
	input  wire          rst,        // Async reset
	input  wire          tick,       // 20 ms time base
	input  wire          in_a,       // Open / cart-out level
	input  wire          in_b,       // Closed / cart-in level
	input  wire [TW-1:0] traverse,   // Traverse time in ticks
	output reg  [1:0]    pos         // Decoded position
);
	reg [TW-1:0] cnt;
	wire         settled = (in_a ^ in_b);

	always @(posedge mclk or posedge rst) begin
		if (rst) begin
			cnt <= {TW{1'b0}};
			pos <= `BOC_POS_INTER;
		end else if (settled) begin
			cnt <= {TW{1'b0}};
			pos <= in_a ? `BOC_POS_OPEN : `BOC_POS_CLOSED;
		end else if (cnt >= traverse) begin
			pos <= in_a ? `BOC_POS_BAD : `BOC_POS_INTER;
		end else if (tick) begin
			cnt <= cnt + {{(TW-1){1'b0}}, 1'b1};
		end
	end
endmodule // boc_pos_decode
`default_nettype wire

// file: core/boc_object_ctrl.v
`timescale 1ns/1ns
`default_nettype none
`include "boc_regs.vh"
module boc_object_ctrl #(
	parameter TW       = 16,
	parameter CW       = 32,
	parameter TICK_CYC = `BOC_TICK_CYC
) (
	input  wire          mclk,            // 25 MHz system clock
	input  wire          rst,             // Async reset, active high
	input  wire          open_status_in,  // Object open contact
	input  wire          close_status_in, // Object closed contact
	input  wire          cart_inserted_input, // Cart racked in
	input  wire          cart_removed_input,  // Cart pulled out
	input  wire          ready_in,        // Object ready, spring charged
	input  wire          sync_ok_in,      // Synchronism permission
	input  wire          local_open,      // Local push-button open
	input  wire          local_close,     // Local push-button close
	input  wire          remote_open,     // Remote terminal open
	input  wire          remote_close,    // Remote terminal close
	input  wire          app_open,        // Application logic open
	input  wire          app_close,       // Application logic close
	input  wire          panel_open,      // Panel open request
	input  wire          panel_close,     // Panel close request
	input  wire [1:0]    panel_level,     // Access level of panel user
	input  wire [1:0]    panel_level_req, // Required access level
	input  wire [1:0]    object_type,     // Object type select
	input  wire          use_sync,        // Synchronism check enable
	input  wire [1:0]    use_ready,       // Ready check mode
	input  wire [TW-1:0] traverse_time,   // Ticks of 20 ms
	input  wire [TW-1:0] close_pulse_max, // Ticks of 20 ms
	input  wire [TW-1:0] open_pulse_max,  // Ticks of 20 ms
	input  wire [TW-1:0] term_timeout,    // Ticks of 20 ms
	input  wire [TW-1:0] ftrip_len,       // Ticks; zero means continuous
	input  wire          ar_in_control,   // Autoreclose controls object
	input  wire          ar_final,        // No further reclosings expected
	input  wire          clear_stats,     // Clear all counters
	output reg           open_cmd,        // Open relay output
	output reg           close_cmd,       // Close relay output
	output reg  [1:0]    breaker_pos,     // Breaker position
	output reg  [1:0]    cart_pos,        // Cart position
	output reg           cart_in_use,     // Cart monitoring active
	output reg           final_trip,      // Final-trip output
	output reg           open_fail,       // Pulse: open timed out
	output reg           close_fail,      // Pulse: close timed out
	output reg           close_blocked,   // Close currently refused
	output reg  [CW-1:0] open_ok_cnt,     // Successful opens
	output reg  [CW-1:0] close_ok_cnt,    // Successful closes
	output reg  [CW-1:0] open_fail_cnt,   // Failed opens
	output reg  [CW-1:0] close_fail_cnt   // Failed closes
);
	localparam S_IDLE  = 2'h0;
	localparam S_OPEN  = 2'h1;
	localparam S_CLOSE = 2'h2;

	function [TW-1:0] inc;
		input [TW-1:0] v;
		inc = v + {{(TW-1){1'b0}}, 1'b1};
	endfunction

	// Two-stage synchronisers for the contact and command inputs
	reg [13:0] sync1;
	reg [13:0] sync2;
	always @(posedge mclk or posedge rst) begin
		if (rst) begin
			sync1 <= 14'h0000;
			sync2 <= 14'h0000;
		end else begin
			sync1 <= {open_status_in, close_status_in, cart_inserted_input,
				cart_removed_input, ready_in, sync_ok_in, local_open,
				local_close, remote_open, remote_close, app_open,
				app_close, panel_open, panel_close};
			sync2 <= sync1;
		end
	end
	wire s_open   = sync2[13];
	wire s_closed = sync2[12];
	wire s_cin    = sync2[11];
	wire s_cout   = sync2[10];
	wire s_ready  = sync2[9];
	wire s_sync   = sync2[8];

	// 20 ms tick
	reg [31:0] tdiv;
	reg        tick;
	always @(posedge mclk or posedge rst) begin
		if (rst) begin
			tdiv <= 32'h0;
			tick <= 1'b0;
		end else if (tdiv == TICK_CYC - 1) begin
			tdiv <= 32'h0;
			tick <= 1'b1;
		end else begin
			tdiv <= tdiv + 32'h1;
			tick <= 1'b0;
		end
	end

	wire [1:0] bpos;
	wire [1:0] wpos;
	boc_pos_decode #(.TW(TW)) u_brk (
		.mclk     (mclk),
		.rst      (rst),
		.tick     (tick),
		.in_a     (s_open),
		.in_b     (s_closed),
		.traverse (traverse_time),
		.pos      (bpos)
	);
	boc_pos_decode #(.TW(TW)) u_cart (
		.mclk     (mclk),
		.rst      (rst),
		.tick     (tick),
		.in_a     (s_cout),
		.in_b     (s_cin),
		.traverse (traverse_time),
		.pos      (wpos)
	);

	wire is_wd  = (object_type == `BOC_TYPE_WD);
	wire is_cb  = (object_type == `BOC_TYPE_CB);
	wire can_op = (object_type != `BOC_TYPE_GND);
	wire checks = is_wd | is_cb;
	wire rdy_ok = (use_ready == `BOC_RDY_HIGH) ? s_ready :
		(use_ready == `BOC_RDY_LOW) ? ~s_ready : 1'b1;
	wire sy_ok  = ~use_sync | s_sync;
	wire close_perm = ~checks | (rdy_ok & sy_ok);
	wire panel_ok = (panel_level >= panel_level_req);
	wire req_open  = sync2[7] | sync2[5] | sync2[3] |
		(sync2[1] & panel_ok);
	wire req_close = sync2[6] | sync2[4] | sync2[2] |
		(sync2[0] & panel_ok);

	// Edge detect so a held input issues one command
	reg prev_open;
	reg prev_close;
	wire new_open  = req_open & ~prev_open;
	wire new_close = req_close & ~prev_close;

	reg [1:0]    state;
	reg [TW-1:0] pcnt;
	reg [TW-1:0] tcnt;
	reg [TW-1:0] fcnt;
	reg          was_closed;
	always @(posedge mclk or posedge rst) begin
		if (rst) begin
			prev_open <= 1'b0;
			prev_close <= 1'b0;
			state <= S_IDLE;
			pcnt <= {TW{1'b0}};
			tcnt <= {TW{1'b0}};
			fcnt <= {TW{1'b0}};
			was_closed <= 1'b0;
			open_cmd <= 1'b0;
			close_cmd <= 1'b0;
			breaker_pos <= `BOC_POS_INTER;
			cart_pos <= `BOC_POS_INTER;
			cart_in_use <= 1'b0;
			final_trip <= 1'b0;
			open_fail <= 1'b0;
			close_fail <= 1'b0;
			close_blocked <= 1'b0;
			open_ok_cnt <= {CW{1'b0}};
			close_ok_cnt <= {CW{1'b0}};
			open_fail_cnt <= {CW{1'b0}};
			close_fail_cnt <= {CW{1'b0}};
		end else begin
			prev_open <= req_open;
			prev_close <= req_close;
			breaker_pos <= bpos;
			cart_in_use <= is_wd;
			cart_pos <= is_wd ? wpos : `BOC_POS_INTER;
			close_blocked <= ~can_op | ~close_perm;
			open_fail <= 1'b0;
			close_fail <= 1'b0;
			case (state)
			S_IDLE: begin
				pcnt <= {TW{1'b0}};
				tcnt <= {TW{1'b0}};
				if (can_op && new_open && bpos != `BOC_POS_OPEN) begin
					state <= S_OPEN;
					open_cmd <= 1'b1;
				end else if (can_op && new_close && close_perm &&
						bpos != `BOC_POS_CLOSED) begin
					state <= S_CLOSE;
					close_cmd <= 1'b1;
				end
			end
			S_OPEN, S_CLOSE: begin
				// Requests ignored until operation ends
				if (tick) begin
					pcnt <= inc(pcnt);
					tcnt <= inc(tcnt);
				end
				if (state == S_OPEN && bpos == `BOC_POS_OPEN) begin
					open_cmd <= 1'b0;
					state <= S_IDLE;
					open_ok_cnt <= open_ok_cnt + {{(CW-1){1'b0}}, 1'b1};
				end else if (state == S_CLOSE && bpos == `BOC_POS_CLOSED) begin
					close_cmd <= 1'b0;
					state <= S_IDLE;
					close_ok_cnt <= close_ok_cnt + {{(CW-1){1'b0}}, 1'b1};
				end else if (tcnt >= term_timeout) begin
					open_cmd <= 1'b0;
					close_cmd <= 1'b0;
					state <= S_IDLE;
					if (state == S_OPEN) begin
						open_fail <= 1'b1;
						open_fail_cnt <= open_fail_cnt +
							{{(CW-1){1'b0}}, 1'b1};
					end else begin
						close_fail <= 1'b1;
						close_fail_cnt <= close_fail_cnt +
							{{(CW-1){1'b0}}, 1'b1};
					end
				end else begin
					if (pcnt >= open_pulse_max)
						open_cmd <= 1'b0;
					if (pcnt >= close_pulse_max)
						close_cmd <= 1'b0;
				end
			end
			default: state <= S_IDLE;
			endcase
			if (clear_stats) begin
				open_ok_cnt <= {CW{1'b0}};
				close_ok_cnt <= {CW{1'b0}};
				open_fail_cnt <= {CW{1'b0}};
				close_fail_cnt <= {CW{1'b0}};
			end
			// Final trip on closed-to-open transition
			if (bpos == `BOC_POS_CLOSED)
				was_closed <= 1'b1;
			else if (bpos == `BOC_POS_OPEN)
				was_closed <= 1'b0;
			if (was_closed && bpos == `BOC_POS_OPEN &&
					(~ar_in_control | ar_final)) begin
				final_trip <= 1'b1;
				fcnt <= {TW{1'b0}};
			end else if (final_trip && ftrip_len != {TW{1'b0}}) begin
				if (fcnt >= ftrip_len - {{(TW-1){1'b0}}, 1'b1} && tick)
					final_trip <= 1'b0;
				else if (tick)
					fcnt <= inc(fcnt);
			end
		end
	end
endmodule // boc_object_ctrl
`default_nettype wire

// file: testbench/boc_object_ctrl_chk.sv
`timescale 1ns/1ns
`default_nettype none
module boc_chk #(parameter TW = 16, parameter TICK_CYC = 10) (
	input wire logic          mclk,            // Clock
	input wire logic          rst,             // Reset
	input wire logic          open_status_in,  // Open contact
	input wire logic          close_status_in, // Closed contact
	input wire logic          sync_ok_in,      // Sync permission
	input wire logic [1:0]    object_type,     // Object type
	input wire logic          use_sync,        // Sync check on
	input wire logic [TW-1:0] close_pulse_max, // Close pulse limit
	input wire logic [TW-1:0] open_pulse_max,  // Open pulse limit
	input wire logic          ar_in_control,   // Autoreclose owns object
	input wire logic          ar_final,        // No reclose left
	input wire logic          open_cmd,        // Open relay
	input wire logic          close_cmd,       // Close relay
	input wire logic [1:0]    breaker_pos,     // Position
	input wire logic          final_trip,      // Final trip
	input wire logic [TW-1:0] ftrip_len,       // Final trip length
	input wire logic          open_fail,       // Open timeout pulse
	input wire logic          close_fail       // Close timeout pulse
);
	int oc;
	int cc;
	default clocking @(posedge mclk); endclocking
	default disable iff (rst);
	// First tick may land up to a full tick late, hence the +1
	always @(posedge mclk or posedge rst) begin
		oc <= rst ? 0 : (open_cmd ? oc + 1 : 0);
		cc <= rst ? 0 : (close_cmd ? cc + 1 : 0);
	end
	sequence s_fail_pulse;
		open_fail ##1 !open_fail;
	endsequence
	sequence s_cfail_pulse;
		close_fail ##1 !close_fail;
	endsequence
	AST_EXCL: assert property (!(open_cmd && close_cmd))
		else $error("both relays driven");
	AST_GND: assert property (object_type == 2'h3 |=> !$rose(open_cmd) && !$rose(close_cmd))
		else $error("command on earthing switch");
	AST_OMAX: assert property (oc <= (open_pulse_max + 1) * TICK_CYC + 4)
		else $error("open pulse too long");
	AST_CMAX: assert property (cc <= (close_pulse_max + 1) * TICK_CYC + 4)
		else $error("close pulse too long");
	AST_OFAIL: assert property ($rose(open_fail) |-> s_fail_pulse)
		else $error("open fail not a single pulse");
	AST_SYNC: assert property ($rose(close_cmd) && use_sync && !object_type[1] |-> $past(sync_ok_in, 3))
		else $error("close without sync permission");
	AST_BAD: assert property ($changed(breaker_pos) && breaker_pos == 2'h3 |-> $past(open_status_in, 4) && $past(close_status_in, 4))
		else $error("bad position without both contacts");
	AST_FT: assert property ($rose(final_trip) |-> !$past(ar_in_control) || $past(ar_final))
		else $error("final trip while reclosing pending");
	AST_CFAIL: assert property ($rose(close_fail) |-> !close_cmd ##0 s_cfail_pulse)
		else $error("close fail not a single pulse after relay release");
	AST_FTHOLD: assert property (final_trip && ftrip_len == {TW{1'b0}} |=> final_trip)
		else $error("continuous final trip dropped");
endmodule // boc_chk
bind boc_object_ctrl boc_chk #(.TW(TW), .TICK_CYC(TICK_CYC)) u_chk (.*);
`default_nettype wire

// file: testbench/boc_brk_model.sv
`timescale 1ns/1ns
`default_nettype none
module boc_brk_model (
	input  wire logic       mclk,      // Clock
	input  wire logic       open_cmd,  // Open relay
	input  wire logic       close_cmd, // Close relay
	input  wire logic       stuck,     // Mechanism jammed
	input  wire logic       both,      // Contact fault, both set
	input  wire logic [7:0] travel,    // Travel cycles
	output wire logic       open_st,   // Open contact
	output wire logic       close_st   // Closed contact
);
	logic       is_open = 1'b0;
	logic       dir     = 1'b0;
	logic [7:0] cnt     = 8'h00;
	// Both contacts drop while in travel
	assign open_st  = both | (cnt == 8'h00 & is_open);
	assign close_st = both | (cnt == 8'h00 & !is_open);
	always @(posedge mclk) begin
		if (cnt != 8'h00) begin
			cnt <= cnt - 8'h01;
			if (cnt == 8'h01)
				is_open <= dir;
		end else if (!stuck && (open_cmd ? !is_open : close_cmd && is_open)) begin
			cnt <= travel;
			dir <= open_cmd;
		end
	end
endmodule // boc_brk_model
`default_nettype wire

// file: testbench/tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module tb_top;
	logic        mclk = 1'b0, rst = 1'b1, stuck = 1'b0, both = 1'b0, pos_o = 1'b0;
	logic        ready_in = 1'b1, sync_ok_in = 1'b1, use_sync = 1'b0;
	logic        cart_inserted_input = 1'b1, cart_removed_input = 1'b0;
	logic        ar_in_control = 1'b0, ar_final = 1'b0, clear_stats = 1'b0;
	logic [7:0]  src = 8'h00, travel = 8'h05;
	logic [1:0]  panel_level = 2'h2, panel_level_req = 2'h2;
	logic [1:0]  object_type = 2'h0, use_ready = 2'h0;
	logic [15:0] traverse_time = 16'h0003, close_pulse_max = 16'h0004;
	logic [15:0] open_pulse_max = 16'h0004, term_timeout = 16'h0014;
	logic [15:0] ftrip_len = 16'h0002;
	int          fails = 0, checks_done = 0;
	int          cnt[4] = '{0, 0, 0, 0};
	wire logic   open_status_in, close_status_in, open_cmd, close_cmd;
	wire logic   cart_in_use, final_trip, open_fail, close_fail, close_blocked;
	wire logic [1:0]  breaker_pos, cart_pos;
	wire logic [31:0] open_ok_cnt, close_ok_cnt, open_fail_cnt, close_fail_cnt;
	always #20 mclk = ~mclk;
	boc_object_ctrl #(.TICK_CYC(10)) dut (.local_open(src[0]), .local_close(src[1]),
		.remote_open(src[2]), .remote_close(src[3]), .app_open(src[4]),
		.app_close(src[5]), .panel_open(src[6]), .panel_close(src[7]), .*);
	boc_brk_model brk (.mclk(mclk), .open_cmd(open_cmd), .close_cmd(close_cmd),
		.stuck(stuck), .both(both), .travel(travel),
		.open_st(open_status_in), .close_st(close_status_in));
	task automatic chk(input string nm, input logic [31:0] seen, exp);
		checks_done++;
		if (seen !== exp) begin
			fails++;
			$display("unexpected %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge mclk);
	endtask
	task automatic cmp();
		chk("open_ok_cnt", open_ok_cnt, cnt[0]);
		chk("close_ok_cnt", close_ok_cnt, cnt[1]);
		chk("open_fail_cnt", open_fail_cnt, cnt[2]);
		chk("close_fail_cnt", close_fail_cnt, cnt[3]);
	endtask
	// Even source bits open, odd ones close; ok says the model expects motion
	task automatic op(input int s, input bit ok);
		cyc(4);
		src[s] <= 1'b1;
		cyc(6);
		src[s] <= 1'b0;
		for (int i = 0; i < 600 && (open_cmd || close_cmd); i++)
			cyc(1);
		cyc(8);
		if (ok) begin
			cnt[s % 2]++;
			pos_o = (s % 2 == 0);
		end
		chk("breaker_pos", breaker_pos, pos_o ? 2'h1 : 2'h2);
	endtask
	task automatic conclude();
		$display("checks %0d mismatches %0d", checks_done, fails);
		if (fails == 0 && checks_done > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	initial begin
		cyc(8000);
		fails++;
		conclude();
	end
	initial begin
		void'($urandom(38196));
		cyc(5);
		rst <= 1'b0;
		cyc(10);
		chk("breaker_pos", breaker_pos, 2'h2);
		chk("cart_pos", cart_pos, 2'h2);
		chk("cart_in_use", cart_in_use, 1'b1);
		for (int k = 0; k < 6; k++) begin
			travel <= 8'(2 + $urandom % 20);
			op(k, 1);
			if (k % 2 == 0) begin
				chk("final_trip", final_trip, 1'b1);
				cyc(40);
				chk("final_trip", final_trip, 1'b0);
			end
		end
		cmp();
		$display("test sources done");
		panel_level <= 2'h1;
		op(6, 0);
		panel_level <= 2'h3;
		op(6, 1);
		use_ready <= 2'h1;
		ready_in <= 1'b0;
		op(1, 0);
		chk("close_blocked", close_blocked, 1'b1);
		use_ready <= 2'h2;
		ready_in <= 1'b1;
		op(1, 0);
		chk("close_blocked", close_blocked, 1'b1);
		use_ready <= 2'h1;
		use_sync <= 1'b1;
		sync_ok_in <= 1'b0;
		op(3, 0);
		chk("close_blocked", close_blocked, 1'b1);
		sync_ok_in <= 1'b1;
		op(5, 1);
		object_type <= 2'h2;
		ready_in <= 1'b0;
		sync_ok_in <= 1'b0;
		op(0, 1);
		op(7, 1);
		chk("cart_in_use", cart_in_use, 1'b0);
		chk("close_blocked", close_blocked, 1'b0);
		$display("test permissions done");
		object_type <= 2'h1;
		ready_in <= 1'b1;
		sync_ok_in <= 1'b1;
		ar_in_control <= 1'b1;
		op(2, 1);
		chk("final_trip", final_trip, 1'b0);
		op(3, 1);
		stuck <= 1'b1;
		op(0, 0);
		for (int i = 0; i < 220 && !open_fail; i++)
			cyc(1);
		chk("open_fail", open_fail, 1'b1);
		cnt[2]++;
		cmp();
		stuck <= 1'b0;
		both <= 1'b1;
		cyc(10);
		chk("breaker_pos", breaker_pos, 2'h2);
		cyc(40);
		chk("breaker_pos", breaker_pos, 2'h3);
		both <= 1'b0;
		travel <= 8'd60;
		ar_final <= 1'b1;
		ftrip_len <= 16'h0000;
		cyc(10);
		src[0] <= 1'b1;
		cyc(30);
		src[1] <= 1'b1; // Pulse active, must be ignored
		cyc(25);
		chk("breaker_pos", breaker_pos, 2'h0);
		src <= 8'h00;
		cyc(100);
		cnt[0]++;
		pos_o = 1'b1;
		chk("breaker_pos", breaker_pos, 2'h1);
		chk("final_trip", final_trip, 1'b1);
		stuck <= 1'b1;
		op(7, 0);
		for (int i = 0; i < 220 && !close_fail; i++)
			cyc(1);
		chk("close_fail", close_fail, 1'b1);
		cnt[3]++;
		stuck <= 1'b0;
		chk("final_trip", final_trip, 1'b1);
		$display("test faults done");
		object_type <= 2'h3;
		op(1, 0);
		chk("close_blocked", close_blocked, 1'b1);
		cmp();
		clear_stats <= 1'b1;
		cyc(1);
		clear_stats <= 1'b0;
		cyc(2);
		cnt = '{0, 0, 0, 0};
		cmp();
		$display("test clear done");
		conclude();
	end
endmodule // tb_top
`default_nettype wire
